/* File: hw/cwg_pkg.sv */
/*
  Constants and types for the complementary waveform generator.
  Assumes a 40 MHz module clock and a plain register port.
*/
`default_nettype none
package cwg_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [3:0] CWG_CTRL0_ADDR = 4'h0;
  localparam logic [3:0] CWG_POL_ADDR = 4'h1;
  localparam logic [3:0] CWG_CLK_ADDR = 4'h2;
  localparam logic [3:0] CWG_ISM_ADDR = 4'h3;
  localparam logic [3:0] CWG_DBR_ADDR = 4'h4;
  localparam logic [3:0] CWG_DBF_ADDR = 4'h5;
  localparam logic [3:0] CWG_STEER_ADDR = 4'h6;
  localparam logic [3:0] CWG_SHUT_ADDR = 4'h7;
  localparam logic [3:0] CWG_STAT_ADDR = 4'h8;
  // ************************************************************
  // fields
  // ************************************************************
  localparam int CWG_EN_BIT = 7;
  localparam int CWG_LD_BIT = 6;
  localparam int CWG_SHDN_BIT = 6;
  localparam int CWG_REN_BIT = 7;
  localparam int CWG_LSBD_BIT = 3;
  localparam int CWG_DB_W = 6;
  localparam int CWG_ISM_W = 4;
  localparam logic [3:0] CWG_ISM_COUNT = 4'hE;
  localparam logic [7:0] CWG_RESET_VAL = 8'h00;
  // ************************************************************
  // modes
  // ************************************************************
  localparam logic [2:0] CWG_MODE_ASTEER = 3'h0;
  localparam logic [2:0] CWG_MODE_SSTEER = 3'h1;
  localparam logic [2:0] CWG_MODE_FWD = 3'h2;
  localparam logic [2:0] CWG_MODE_REV = 3'h3;
  localparam logic [2:0] CWG_MODE_HALF = 3'h4;
  localparam logic [2:0] CWG_MODE_PP = 3'h5;
  // ************************************************************
  // clock rates
  // ************************************************************
  localparam int CWG_SYS_MHZ = 40;
  localparam int CWG_HF_MHZ = 16;
  typedef enum logic [1:0] {CWG_DB_IDLE, CWG_DB_RISE, CWG_DB_FALL} cwg_db_type;
endpackage : cwg_pkg
`default_nettype wire

/* File: hw/cwg_top.sv */
/*
  Complementary waveform generator: input select, dead band, steering,
  push-pull, full bridge, polarity and auto-shutdown on four outputs.
  Assumes synchronous inputs and a single 40 MHz clock; the 16 MHz
  oscillator choice is a fractional enable pulse from that clock.
*/
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - six modes selected by the three mode bits of control register 0
// - half bridge: A true input, B inverted, dead band between them
// - half bridge: C and D copy A and B with own polarity
// - push-pull: successive input pulses go alternately to A and B
// - push-pull sequencer resets when disabled or shut down; first pulse on A
// - push-pull: C and D replicate A and B with own polarity bits
// - forward bridge: A active, B and C inactive, D modulated
// - reverse bridge: C active, A and D inactive, B modulated
// - direction flips by mode bit 0 alone while running
// - direction change: A and C switch on rising edge, modulated output delayed
// - synchronous steering: steer enable writes apply at next input rising edge; level bits apply at once
// - asynchronous steering: steer writes apply on the next cycle
// - clock bit selects system clock or 16 MHz oscillator rate
// - input select register picks one of fourteen sources
// - each output polarity bit: set active high, clear active low
// - polarity ignores override levels, shutdown and steering behaviour
// - two 6-bit dead-band count registers sharing one counter, rising/reverse and falling/forward
// - dead band counts module clocks from zero to register value
// - dead band only in half and full bridge modes
// - half bridge: delay each rising edge after opposite falling edge
// - auto-shutdown forces override levels; in steering modes only on steered outputs
// - mode 000 is asynchronous steering, 001 synchronous
// - steering: clear bit holds fixed level, set bit follows data
// - shutdown inputs level sensitive active low; no clear while asserted
module cwg_top #(
  parameter int SRC_COUNT = 14
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // waveform sources and shutdown inputs (active low)
  input wire logic [SRC_COUNT-1:0] srcIn,
  input wire logic [3:0] shutdownSrcN,
  // bridge outputs
  output logic bridge_output_a,
  output logic bridge_output_b,
  output logic bridge_output_c,
  output logic bridge_output_d
);
  // source index is a 4-bit select over exactly fourteen inputs
  if (SRC_COUNT != 14)
  begin : g_src_check
    $error("cwg_top: SRC_COUNT must be 14");
  end
  // ************************************************************
  // registers
  // ************************************************************
  logic enable, loadReq, next_loadReq;
  logic [2:0] mode;
  logic [3:0] output_polarity_bits;
  logic clkSel;
  logic [3:0] input_source_select;
  logic [5:0] rising_deadband_count, falling_deadband_count;
  logic [5:0] dbrLive, dbfLive, next_dbrLive, next_dbfLive;
  logic [3:0] steer_enable_bits, steerLive, next_steerLive;
  logic [3:0] steerLevel;
  logic [3:0] shutSel;
  logic [1:0] lsac, lsbd;
  logic swShut, next_swShut, autoRestart;
  logic [7:0] next_regRdata;
  logic wrCtrl0;
  always_comb
  begin
    wrCtrl0 = regWr && regAddr == cwg_pkg::CWG_CTRL0_ADDR;
  end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      enable <= 1'b0;
      mode <= 3'h0;
      output_polarity_bits <= 4'h0;
      clkSel <= 1'b0;
      input_source_select <= 4'h0;
      rising_deadband_count <= 6'h00;
      falling_deadband_count <= 6'h00;
      steer_enable_bits <= 4'h0;
      steerLevel <= 4'h0;
      shutSel <= 4'h0;
      lsac <= 2'h0;
      lsbd <= 2'h0;
      autoRestart <= 1'b0;
    end
    else if (regWr)
    begin
      case (regAddr)
        cwg_pkg::CWG_CTRL0_ADDR:
        begin
          enable <= regWdata[cwg_pkg::CWG_EN_BIT];
          mode <= regWdata[2:0];
        end
        cwg_pkg::CWG_POL_ADDR: output_polarity_bits <= regWdata[3:0];
        cwg_pkg::CWG_CLK_ADDR: clkSel <= regWdata[0];
        cwg_pkg::CWG_ISM_ADDR: input_source_select <= regWdata[3:0];
        cwg_pkg::CWG_DBR_ADDR: rising_deadband_count <= regWdata[5:0];
        cwg_pkg::CWG_DBF_ADDR: falling_deadband_count <= regWdata[5:0];
        cwg_pkg::CWG_STEER_ADDR:
        begin
          steer_enable_bits <= regWdata[3:0];
          steerLevel <= regWdata[7:4];
        end
        cwg_pkg::CWG_SHUT_ADDR:
        begin
          shutSel <= regWdata[3:0];
          lsac <= regWdata[5:4];
          lsbd <= {1'b0, regWdata[cwg_pkg::CWG_LSBD_BIT]};
          autoRestart <= regWdata[cwg_pkg::CWG_REN_BIT];
        end
        default:
        begin
        end
      endcase
    end
  end
  // ************************************************************
  // module clock enable
  // ************************************************************
  logic [5:0] clkAcc, next_clkAcc;
  logic modTick;
  always_comb
  begin
    next_clkAcc = clkAcc;
    modTick = 1'b1;
    if (clkSel)
    begin
      if (clkAcc + 6'(cwg_pkg::CWG_HF_MHZ) >= 6'(cwg_pkg::CWG_SYS_MHZ))
      begin
        next_clkAcc = 6'(clkAcc + 6'(cwg_pkg::CWG_HF_MHZ) - 6'(cwg_pkg::CWG_SYS_MHZ));
      end
      else
      begin
        next_clkAcc = 6'(clkAcc + 6'(cwg_pkg::CWG_HF_MHZ));
        modTick = 1'b0;
      end
    end
  end
  // ************************************************************
  // input select and synchroniser
  // ************************************************************
  logic selRaw, sync1, sync2, dataQ;
  logic riseEv, fallEv;
  always_comb
  begin
    selRaw = (input_source_select < cwg_pkg::CWG_ISM_COUNT) ?
      srcIn[input_source_select] : 1'b0;
    riseEv = sync2 && !dataQ;
    fallEv = !sync2 && dataQ;
  end
  // ************************************************************
  // shutdown
  // ************************************************************
  logic shutLevel, shutState;
  always_comb
  begin
    shutLevel = |(shutSel & ~shutdownSrcN);
    shutState = swShut || shutLevel;
    next_swShut = swShut;
    if (shutLevel)
    begin
      next_swShut = 1'b1;
    end
    else if (regWr && regAddr == cwg_pkg::CWG_SHUT_ADDR)
    begin
      next_swShut = regWdata[cwg_pkg::CWG_SHDN_BIT];
    end
    else if (autoRestart && riseEv)
    begin
      next_swShut = 1'b0;
    end
  end
  // ************************************************************
  // dead band, push-pull and steering
  // ************************************************************
  logic isHalf, isFull, isSteer;
  logic [5:0] dbCnt, next_dbCnt;
  cwg_pkg::cwg_db_type dbState, next_dbState;
  logic outA, outB, next_outA, next_outB;
  logic ppSel, next_ppSel, dirQ, next_dirQ;
  logic [3:0] act;
  always_comb
  begin
    isHalf = mode == cwg_pkg::CWG_MODE_HALF;
    isFull = mode == cwg_pkg::CWG_MODE_FWD || mode == cwg_pkg::CWG_MODE_REV;
    isSteer = mode == cwg_pkg::CWG_MODE_ASTEER || mode == cwg_pkg::CWG_MODE_SSTEER;
    next_loadReq = loadReq;
    next_dbrLive = dbrLive;
    next_dbfLive = dbfLive;
    if (!enable)
    begin
      next_dbrLive = rising_deadband_count;
      next_dbfLive = falling_deadband_count;
      next_loadReq = 1'b0;
    end
    else if (wrCtrl0 && regWdata[cwg_pkg::CWG_LD_BIT])
    begin
      next_loadReq = 1'b1;
    end
    else if (loadReq && fallEv)
    begin
      next_dbrLive = rising_deadband_count;
      next_dbfLive = falling_deadband_count;
      next_loadReq = 1'b0;
    end
    next_steerLive = steerLive;
    if (mode != cwg_pkg::CWG_MODE_SSTEER || riseEv)
    begin
      next_steerLive = steer_enable_bits;
    end
    next_ppSel = ppSel;
    if (!enable || shutState)
    begin
      next_ppSel = 1'b0;
    end
    else if (fallEv && mode == cwg_pkg::CWG_MODE_PP)
    begin
      next_ppSel = !ppSel;
    end
    next_dirQ = dirQ;
    next_dbState = dbState;
    next_dbCnt = dbCnt;
    next_outA = outA;
    next_outB = outB;
    if (dbState != cwg_pkg::CWG_DB_IDLE && modTick)
    begin
      next_dbCnt = 6'(dbCnt + 6'h01);
    end
    case (dbState)
      cwg_pkg::CWG_DB_IDLE:
      begin
        if (isHalf && riseEv)
        begin
          next_outB = 1'b0;
          next_dbCnt = 6'h00;
          next_dbState = cwg_pkg::CWG_DB_RISE;
        end
        else if (isHalf && fallEv)
        begin
          next_outA = 1'b0;
          next_dbCnt = 6'h00;
          next_dbState = cwg_pkg::CWG_DB_FALL;
        end
        else if (isFull && riseEv && dirQ != mode[0])
        begin
          next_dirQ = mode[0];
          next_dbCnt = 6'h00;
          next_dbState = mode[0] ? cwg_pkg::CWG_DB_RISE : cwg_pkg::CWG_DB_FALL;
        end
      end
      cwg_pkg::CWG_DB_RISE:
      begin
        if (!sync2 && isHalf)
        begin
          next_dbState = cwg_pkg::CWG_DB_IDLE;
        end
        else if (dbCnt >= dbrLive)
        begin
          next_outA = isHalf;
          next_dbState = cwg_pkg::CWG_DB_IDLE;
        end
      end
      cwg_pkg::CWG_DB_FALL:
      begin
        if (sync2 && isHalf)
        begin
          next_dbState = cwg_pkg::CWG_DB_IDLE;
        end
        else if (dbCnt >= dbfLive)
        begin
          next_outB = isHalf;
          next_dbState = cwg_pkg::CWG_DB_IDLE;
        end
      end
      default: next_dbState = cwg_pkg::CWG_DB_IDLE;
    endcase
    if (!isFull)
    begin
      next_dirQ = mode[0];
    end
    // active-level pattern per output, before polarity
    case (mode)
      cwg_pkg::CWG_MODE_HALF: act = {outB, outA, outB, outA};
      cwg_pkg::CWG_MODE_PP:
        act = {sync2 && ppSel, sync2 && !ppSel, sync2 && ppSel, sync2 && !ppSel};
      cwg_pkg::CWG_MODE_FWD, cwg_pkg::CWG_MODE_REV:
      begin
        // modulated leg idles during the direction dead band
        act[0] = !dirQ;
        act[2] = dirQ;
        act[3] = !dirQ && sync2 && dbState == cwg_pkg::CWG_DB_IDLE;
        act[1] = dirQ && sync2 && dbState == cwg_pkg::CWG_DB_IDLE;
      end
      default: act = {4{sync2}};
    endcase
  end
  // ************************************************************
  // output stage
  // ************************************************************
  logic [3:0] next_drive, drive;
  logic [3:0] ovr;
  always_comb
  begin
    ovr = {lsbd[0], lsac[0], lsbd[0], lsac[0]};
    next_drive = act ^ ~output_polarity_bits;
    if (isSteer)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (!steerLive[i])
        begin
          next_drive[i] = steerLevel[i];
        end
      end
    end
    for (int i = 0; i < 4; i++)
    begin
      if (!enable || (shutState && (!isSteer || steerLive[i])))
      begin
        next_drive[i] = ovr[i];
      end
    end
    next_regRdata = 8'h00;
    case (regAddr)
      cwg_pkg::CWG_CTRL0_ADDR: next_regRdata = {enable, loadReq, 3'h0, mode};
      cwg_pkg::CWG_POL_ADDR: next_regRdata = {4'h0, output_polarity_bits};
      cwg_pkg::CWG_CLK_ADDR: next_regRdata = {7'h00, clkSel};
      cwg_pkg::CWG_ISM_ADDR: next_regRdata = {4'h0, input_source_select};
      cwg_pkg::CWG_DBR_ADDR: next_regRdata = {2'h0, rising_deadband_count};
      cwg_pkg::CWG_DBF_ADDR: next_regRdata = {2'h0, falling_deadband_count};
      cwg_pkg::CWG_STEER_ADDR: next_regRdata = {steerLevel, steer_enable_bits};
      cwg_pkg::CWG_SHUT_ADDR: next_regRdata = {autoRestart, swShut, lsac, shutSel};
      cwg_pkg::CWG_STAT_ADDR: next_regRdata = {shutState, sync2, 2'h0, drive};
      default: next_regRdata = 8'h00;
    endcase
  end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clkAcc <= 6'h00;
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      dataQ <= 1'b0;
      swShut <= 1'b1;
      loadReq <= 1'b0;
      dbrLive <= 6'h00;
      dbfLive <= 6'h00;
      steerLive <= 4'h0;
      ppSel <= 1'b0;
      dirQ <= 1'b0;
      dbState <= cwg_pkg::CWG_DB_IDLE;
      dbCnt <= 6'h00;
      outA <= 1'b0;
      outB <= 1'b0;
      drive <= 4'h0;
      regRdata <= cwg_pkg::CWG_RESET_VAL;
    end
    else
    begin
      clkAcc <= next_clkAcc;
      sync1 <= selRaw;
      sync2 <= sync1;
      dataQ <= sync2;
      swShut <= next_swShut;
      loadReq <= next_loadReq;
      dbrLive <= next_dbrLive;
      dbfLive <= next_dbfLive;
      steerLive <= next_steerLive;
      ppSel <= next_ppSel;
      dirQ <= next_dirQ;
      dbState <= next_dbState;
      dbCnt <= next_dbCnt;
      outA <= next_outA;
      outB <= next_outB;
      drive <= next_drive;
      if (regRd)
      begin
        regRdata <= next_regRdata;
      end
    end
  end
  always_comb
  begin
    bridge_output_a = drive[0];
    bridge_output_b = drive[1];
    bridge_output_c = drive[2];
    bridge_output_d = drive[3];
  end
endmodule : cwg_top
`default_nettype wire

/* File: sim/cwg_top_chk.sv */
/* assertion checker on the generator top ports
   bound to cwg_top; shadows register writes to know the set-up */
`timescale 1ns/1ps
`default_nettype none
module cwg_top_chk (
  // clock, reset and register port
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // shutdown inputs and outputs
  input wire logic [3:0] shutdownSrcN,
  input wire logic bridge_output_a,
  input wire logic bridge_output_b,
  input wire logic bridge_output_c,
  input wire logic bridge_output_d
);
  // ****************
  // register shadows
  // ****************
  logic [7:0] sh [0:7];
  logic [7:0] next_sh [0:7];
  logic [3:0] quiet, next_quiet, outs, steer;
  logic en, faultOn, pairMode;
  assign outs = {bridge_output_d, bridge_output_c, bridge_output_b, bridge_output_a};
  assign steer = sh[6][3:0];
  assign en = sh[0][cwg_pkg::CWG_EN_BIT];
  assign faultOn = |(sh[7][3:0] & ~shutdownSrcN) && sh[7][5:3] == 3'h0;
  assign pairMode = sh[0][2:0] == cwg_pkg::CWG_MODE_HALF || sh[0][2:0] == cwg_pkg::CWG_MODE_PP;
  always_comb
  begin
    next_sh = sh;
    next_quiet = (quiet == 4'hF) ? quiet : quiet + 4'h1;
    if (regWr)
    begin
      next_quiet = 4'h0;
      if (regAddr < 4'h8)
        next_sh[regAddr[2:0]] = regWdata;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sh <= '{default: 8'h00};
      quiet <= 4'h0;
    end
    else
    begin
      sh <= next_sh;
      quiet <= next_quiet;
    end
  end
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  chk_pol_readback: assert property (
    regRd && regAddr == cwg_pkg::CWG_POL_ADDR |=> regRdata[3:0] == sh[1][3:0])
    else $error("polarity readback differs");
  chk_ism_readback: assert property (
    regRd && regAddr == cwg_pkg::CWG_ISM_ADDR |=> regRdata[3:0] == sh[3][3:0])
    else $error("input select readback differs");
  chk_db_readback: assert property (
    regRd && regAddr == cwg_pkg::CWG_DBR_ADDR |=> regRdata[5:0] == sh[4][5:0])
    else $error("dead band readback differs");
  chk_fault_override: assert property (
    (faultOn && sh[0][2:1] != 2'b00) [*6] |-> outs == 4'h0)
    else $error("outputs not overridden in fault");
  chk_fault_status: assert property (
    faultOn [*4] ##0 (regRd && regAddr == cwg_pkg::CWG_STAT_ADDR) |=> regRdata[7] == 1'b1)
    else $error("shutdown flag clear in fault");
  chk_ab_apart: assert property (
    quiet >= 4'h8 && en && pairMode && sh[1][1:0] == 2'b11 |-> !(outs[0] && outs[1]))
    else $error("outputs a and b overlap");
  chk_cd_apart: assert property (
    quiet >= 4'h8 && en && pairMode && sh[1][3:2] == 2'b11 |-> !(outs[2] && outs[3]))
    else $error("outputs c and d overlap");
  chk_steer_fixed: assert property (
    quiet >= 4'h4 && en && sh[0][2:0] == cwg_pkg::CWG_MODE_ASTEER
    |-> (outs & ~steer) == (sh[6][7:4] & ~steer))
    else $error("unsteered output not at fixed level");
endmodule : cwg_top_chk
bind cwg_top cwg_top_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .shutdownSrcN(shutdownSrcN), .bridge_output_a(bridge_output_a),
  .bridge_output_b(bridge_output_b), .bridge_output_c(bridge_output_c),
  .bridge_output_d(bridge_output_d));
`default_nettype wire

/* File: sim/cwg_load_model.sv */
/* model of the four switch drivers on the bridge outputs
   counts turn-on events and raises a fault level on request */
`timescale 1ns/1ps
`default_nettype none
module cwg_load_model (
  // clock and drive levels
  input wire logic ref_clk,
  input wire logic faultReq,
  input wire logic [3:0] drive,
  // fault line and turn-on counts
  output logic faultN,
  output int riseCnt [0:3]
);
  // ****************
  // fault and counting
  // ****************
  logic [3:0] last = 4'h0;
  int cnt [0:3] = '{default: 0};
  assign faultN = !faultReq;
  assign riseCnt = cnt;
  always @(posedge ref_clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (drive[i] === 1'b1 && last[i] !== 1'b1)
        cnt[i] <= cnt[i] + 1;
    end
    last <= drive;
  end
endmodule : cwg_load_model
`default_nettype wire

/* File: sim/tb_top.sv */
/* self-checking bench for the waveform generator
   drives the register port and source 3; a driver model loads the outputs */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************
  // signals and instances
  // ****************
  logic ref_clk, nrst, regWr, regRd, faultReq;
  logic [3:0] regAddr;
  logic [7:0] regWdata;
  logic [13:0] src;
  wire [7:0] regRdata;
  wire [3:0] outs;
  wire faultN;
  int riseCnt [0:3];
  int nErrors = 0;
  int nCompared = 0;
  cwg_top #(.SRC_COUNT(14)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .srcIn(src),
    .shutdownSrcN({3'h7, faultN}), .bridge_output_a(outs[0]), .bridge_output_b(outs[1]),
    .bridge_output_c(outs[2]), .bridge_output_d(outs[3]));
  cwg_load_model u_load (.ref_clk(ref_clk), .faultReq(faultReq), .drive(outs),
    .faultN(faultN), .riseCnt(riseCnt));
  // ****************
  // bus and compare tasks
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      nErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkOut(input logic [3:0] exp);
    @(negedge ref_clk);
    chk({4'h0, outs}, {4'h0, exp});
  endtask : chkOut
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    d = regRdata;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle
  task automatic setIn(input logic v);
    @(posedge ref_clk);
    src[3] <= v;
  endtask : setIn
  task automatic pulse;
    setIn(1'b1);
    idle(20);
    setIn(1'b0);
    idle(20);
  endtask : pulse
  task automatic waitOut(input int i, input logic v, output int c);
    c = 0;
    while (outs[i] !== v && c < 200)
    begin
      @(negedge ref_clk);
      c++;
    end
  endtask : waitOut
  task automatic start(input logic [2:0] m, input logic [7:0] db);
    wr(4'h0, {5'h00, m});
    wr(4'h4, db);
    wr(4'h5, db);
    wr(4'h0, {5'h10, m});
  endtask : start
  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] mask [1:5] = '{8'h0D, 8'h01, 8'h0D, 8'h2D, 8'h2D};
    for (int a = 1; a <= 5; a++)
    begin
      rd(a[3:0], d);
      chk(d, cwg_pkg::CWG_RESET_VAL);
      wr(a[3:0], 8'hAD);
      rd(a[3:0], d);
      chk(d, mask[a]);
    end
    wr(4'hC, 8'hFF);
    rd(4'hC, d);
    chk(d, 8'h00);
    wr(4'h1, 8'h0F);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h03);
    wr(4'h7, 8'h01);
  endtask : t_regs
  task automatic halfRun(input logic [7:0] db, output int tr, output int tf);
    start(cwg_pkg::CWG_MODE_HALF, db);
    setIn(1'b0);
    idle(20);
    setIn(1'b1);
    waitOut(0, 1'b1, tr);
    chk({7'h00, outs[1]}, 8'h00);
    idle(10);
    chkOut(4'b0101);
    setIn(1'b0);
    waitOut(1, 1'b1, tf);
    chk({7'h00, outs[0]}, 8'h00);
    idle(10);
    chkOut(4'b1010);
  endtask : halfRun
  task automatic t_half;
    int r1, f1, r2, f2;
    halfRun(8'h02, r1, f1);
    halfRun(8'h09, r2, f2);
    chk(8'(r2 - r1), 8'h07);
    chk(8'(f2 - f1), 8'h07);
    // 16 MHz rate: nine counts take about 22.5 clocks instead of nine
    wr(4'h2, 8'h01);
    halfRun(8'h09, r1, f1);
    chk({7'h00, r1 - r2 >= 13 && r1 - r2 <= 15}, 8'h01);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h0E);
    idle(6);
    chkOut(4'b1011);
    wr(4'h1, 8'h0F);
  endtask : t_half
  task automatic t_pp;
    int a0, b0, c0;
    start(cwg_pkg::CWG_MODE_PP, 8'h00);
    idle(10);
    a0 = riseCnt[0];
    b0 = riseCnt[1];
    c0 = riseCnt[2];
    pulse();
    chk(8'(riseCnt[0] - a0), 8'h01);
    chk(8'(riseCnt[1] - b0), 8'h00);
    repeat (3) pulse();
    chk(8'(riseCnt[0] - a0), 8'h02);
    chk(8'(riseCnt[1] - b0), 8'h02);
    chk(8'(riseCnt[2] - c0), 8'h02);
  endtask : t_pp
  task automatic t_bridge;
    int tc, tb;
    start(cwg_pkg::CWG_MODE_FWD, 8'h09);
    pulse();
    setIn(1'b1);
    idle(20);
    chkOut(4'b1001);
    setIn(1'b0);
    idle(10);
    chkOut(4'b0001);
    wr(4'h0, {5'h10, cwg_pkg::CWG_MODE_REV});
    idle(10);
    chkOut(4'b0001);
    setIn(1'b1);
    waitOut(2, 1'b1, tc);
    waitOut(1, 1'b1, tb);
    chk({7'h00, tb >= 8}, 8'h01);
    chk({4'h0, outs}, 8'h06);
  endtask : t_bridge
  task automatic t_steer;
    start(cwg_pkg::CWG_MODE_ASTEER, 8'h00);
    wr(4'h6, 8'h81);
    setIn(1'b1);
    idle(10);
    chkOut(4'b1001);
    wr(4'h6, 8'h80);
    idle(3);
    chkOut(4'b1000);
    wr(4'h0, {5'h10, cwg_pkg::CWG_MODE_SSTEER});
    wr(4'h6, 8'h81);
    idle(10);
    chkOut(4'b1000);
    setIn(1'b0);
    idle(8);
    setIn(1'b1);
    idle(8);
    chkOut(4'b1001);
  endtask : t_steer
  task automatic t_shut;
    logic [7:0] d;
    start(cwg_pkg::CWG_MODE_HALF, 8'h00);
    pulse();
    setIn(1'b1);
    idle(10);
    faultReq <= 1'b1;
    idle(8);
    chkOut(4'b0000);
    wr(4'h1, 8'h00);
    idle(4);
    chkOut(4'b0000);
    wr(4'h1, 8'h0F);
    rd(4'h8, d);
    chk({7'h00, d[7]}, 8'h01);
    wr(4'h7, 8'h01);
    idle(4);
    chkOut(4'b0000);
    @(posedge ref_clk);
    faultReq <= 1'b0;
    idle(8);
    chkOut(4'b0000);
    wr(4'h7, 8'h01);
    pulse();
    setIn(1'b1);
    idle(10);
    chkOut(4'b0101);
  endtask : t_shut
  task automatic final_report;
    $display("errors %0d compared %0d", nErrors, nCompared);
    if (nErrors == 0 && nCompared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #(25 * 30000);
    nErrors++;
    final_report();
  end
  initial
  begin
    nrst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    src = 14'h0000;
    faultReq = 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_half();
    t_pp();
    t_bridge();
    t_steer();
    t_shut();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
